// ---- logic/hbsp_regs.vh ----
// hbsp_regs.vh: constants of the half-bridge serial control port
// assumes: included by bare name from the timer and top design files; the synchroniser does not include it
`ifndef HBSP_REGS_VH
`define HBSP_REGS_VH

// ------------------------------------------------------------
// frame and word layout
// ------------------------------------------------------------
`define HBSP_WORD_W 16
`define HBSP_FRAME_BITS 5'h10
`define HBSP_NUM_SW 12
`define HBSP_CTRL_RESET 16'he000
`define HBSP_CTRL_CLR 0
`define HBSP_CTRL_SW_LSB 1
`define HBSP_CTRL_SW_MSB 12
`define HBSP_CTRL_OLD 13
`define HBSP_CTRL_SCT 14
`define HBSP_CTRL_SI 15
`define HBSP_STAT_TP 0
`define HBSP_STAT_SW_LSB 1
`define HBSP_STAT_SW_MSB 12
`define HBSP_STAT_SCD 13
`define HBSP_STAT_INH 14
`define HBSP_STAT_PSF 15

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define HBSP_CLK_MHZ 50
`define HBSP_T_SHORT_LONG_US 12000
`define HBSP_T_SHORT_SHORT_US 1500
`define HBSP_TMR_W 20
// cycle counts at the nominal clock, sized to the timer width
`define HBSP_SHORT_LONG_CYC 20'h927c0
`define HBSP_SHORT_SHORT_CYC 20'h124f8

`endif

// ---- logic/hbsp_sync.v ----
// hbsp_sync.v: two-flop synchroniser for a bundle of asynchronous levels
// assumes: each bit is an independent level; no word coherence is implied
`timescale 1ns/10ps
`default_nettype none
module hbsp_sync #(
	parameter integer W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// the first stage feeds only the second stage
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule // hbsp_sync
`default_nettype wire

// ---- logic/hbsp_short_timer.v ----
// hbsp_short_timer.v: shutdown delay timer for one switch under overcurrent
// assumes: overload_i is already synchronised and qualified by the switch being on
`timescale 1ns/10ps
`default_nettype none
`include "hbsp_regs.vh"
module hbsp_short_timer #(
	parameter [`HBSP_TMR_W-1:0] LONG_CYC = 20'h927c0,
	parameter [`HBSP_TMR_W-1:0] SHORT_CYC = 20'h124f8
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire overload_i,
	input wire long_sel_i,
	input wire clear_i,
	output wire off_o
);
	reg [`HBSP_TMR_W-1:0] cnt_q;
	reg off_q;
	wire [`HBSP_TMR_W-1:0] limit;
	wire expire;

	assign limit = long_sel_i ? LONG_CYC : SHORT_CYC;
	assign expire = overload_i && (cnt_q >= limit - 20'h00001);

	// a short that goes away before the delay restarts the count
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 20'h00000;
			off_q <= 1'b0;
		end else begin
			if (overload_i && !expire) begin
				cnt_q <= cnt_q + 20'h00001;
			end else begin
				cnt_q <= 20'h00000;
			end
			if (expire) begin
				off_q <= 1'b1;
			end else if (clear_i) begin
				off_q <= 1'b0;
			end
		end
	end

	assign off_o = off_q;
endmodule // hbsp_short_timer
`default_nettype wire

// ---- logic/hbsp_top.v ----
// hbsp_top.v: serial control and status port of a six-channel half-bridge driver
// assumes: select, serial clock and data arrive from a master outside clk_i's domain;
// serial clock is slow enough (>= 4 clk_i periods per phase) to be edge-sampled
`timescale 1ns/10ps
`default_nettype none
`include "hbsp_regs.vh"
module hbsp_top #(
	parameter [`HBSP_TMR_W-1:0] SHORT_LONG_CYC = `HBSP_SHORT_LONG_CYC,
	parameter [`HBSP_TMR_W-1:0] SHORT_SHORT_CYC = `HBSP_SHORT_SHORT_CYC
) (
	input wire clk_i,
	input wire reset_n_i,
	input wire select_n_i,
	input wire serial_clk_i,
	input wire serial_in_i,
	input wire standby_pin_n_i,
	input wire temp_prewarn_i,
	input wire temp_shutdown_i,
	input wire supply_undervolt_i,
	input wire [`HBSP_NUM_SW-1:0] overcurrent_i,
	input wire [`HBSP_NUM_SW-1:0] openload_i,
	output wire serial_out_o,
	output wire serial_out_oe_o,
	output wire [`HBSP_NUM_SW-1:0] switch_on_o,
	output wire openload_detect_en_o,
	output wire short_delay_long_o,
	output wire standby_o,
	output wire [`HBSP_WORD_W-1:0] control_word_o,
	output wire [`HBSP_WORD_W-1:0] status_word_o
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function rose;
		input cur;
		input prev;
		begin
			rose = cur & ~prev;
		end
	endfunction

	function fell;
		input cur;
		input prev;
		begin
			fell = ~cur & prev;
		end
	endfunction

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	reg rst_meta_q;
	reg rst_n_q;

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// select idles high; the standby pin reads as standby until sampled
	localparam integer SYNC_W = 7 + 2 * `HBSP_NUM_SW;
	localparam [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-1){1'b0}}, 1'b1};

	wire [SYNC_W-1:0] sync_bus;
	wire cs_n_s;
	wire sclk_s;
	wire din_s;
	wire standby_pin_n_s;
	wire prewarn_s;
	wire shutdown_s;
	wire undervolt_s;
	wire [`HBSP_NUM_SW-1:0] overcurrent_s;
	wire [`HBSP_NUM_SW-1:0] openload_s;

	hbsp_sync #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_q),
		.async_i({openload_i, overcurrent_i, supply_undervolt_i, temp_shutdown_i,
			temp_prewarn_i, standby_pin_n_i, serial_in_i, serial_clk_i, select_n_i}),
		.sync_o(sync_bus)
	);

	assign cs_n_s = sync_bus[0];
	assign sclk_s = sync_bus[1];
	assign din_s = sync_bus[2];
	assign standby_pin_n_s = sync_bus[3];
	assign prewarn_s = sync_bus[4];
	assign shutdown_s = sync_bus[5];
	assign undervolt_s = sync_bus[6];
	assign overcurrent_s = sync_bus[7 +: `HBSP_NUM_SW];
	assign openload_s = sync_bus[7 + `HBSP_NUM_SW +: `HBSP_NUM_SW];

	// ------------------------------------------------------------
	// edge detection on the synchronised link
	// ------------------------------------------------------------
	reg cs_n_prev_q;
	reg sclk_prev_q;
	wire cs_fall;
	wire cs_rise;
	wire sclk_fall;
	wire sclk_rise;

	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cs_n_prev_q <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_n_prev_q <= cs_n_s;
			sclk_prev_q <= sclk_s;
		end
	end

	assign cs_fall = fell(cs_n_s, cs_n_prev_q);
	assign cs_rise = rose(cs_n_s, cs_n_prev_q);
	assign sclk_fall = fell(sclk_s, sclk_prev_q);
	assign sclk_rise = rose(sclk_s, sclk_prev_q);

	// ------------------------------------------------------------
	// control word and sticky fault flags
	// ------------------------------------------------------------
	reg [`HBSP_WORD_W-1:0] ctrl_q;
	reg clear_q;
	reg supply_fail_q;
	reg shutdown_q;
	wire [`HBSP_NUM_SW-1:0] short_off;
	wire standby;
	wire [`HBSP_NUM_SW-1:0] sw_req;

	assign sw_req = ctrl_q[`HBSP_CTRL_SW_MSB:`HBSP_CTRL_SW_LSB];
	assign standby = ~ctrl_q[`HBSP_CTRL_SI] | ~standby_pin_n_s;

	// set wins over clear, so a fault still present is never lost
	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			supply_fail_q <= 1'b0;
			shutdown_q <= 1'b0;
		end else begin
			if (undervolt_s) begin
				supply_fail_q <= 1'b1;
			end else if (clear_q) begin
				supply_fail_q <= 1'b0;
			end
			if (shutdown_s) begin
				shutdown_q <= 1'b1;
			end else if (clear_q) begin
				shutdown_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// short-circuit shutdown per switch
	// ------------------------------------------------------------
	reg [`HBSP_NUM_SW-1:0] switch_on_q;

	genvar g;
	generate
		for (g = 0; g < `HBSP_NUM_SW; g = g + 1) begin : g_short
			hbsp_short_timer #(
				.LONG_CYC(SHORT_LONG_CYC),
				.SHORT_CYC(SHORT_SHORT_CYC)
			) u_timer (
				.clk_i(clk_i),
				.rst_n_i(rst_n_q),
				.overload_i(overcurrent_s[g] & switch_on_q[g]),
				.long_sel_i(ctrl_q[`HBSP_CTRL_SCT]),
				.clear_i(clear_q),
				.off_o(short_off[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// output stage gating
	// ------------------------------------------------------------
	// undervoltage gates live so that outputs return as soon as supply recovers
	wire stages_allowed;

	assign stages_allowed = ~standby & ~shutdown_q & ~undervolt_s;

	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			switch_on_q <= {`HBSP_NUM_SW{1'b0}};
		end else begin
			switch_on_q <= sw_req & ~short_off & {`HBSP_NUM_SW{stages_allowed}};
		end
	end

	// ------------------------------------------------------------
	// status word assembly
	// ------------------------------------------------------------
	reg [`HBSP_WORD_W-1:0] status_now;
	reg [`HBSP_WORD_W-1:0] status_q;
	wire old_en;

	assign old_en = ~ctrl_q[`HBSP_CTRL_OLD];

	always @* begin
		status_now = {`HBSP_WORD_W{1'b0}};
		status_now[`HBSP_STAT_TP] = prewarn_s;
		if (old_en) begin
			// a switched-on stage hides its load condition
			status_now[`HBSP_STAT_SW_MSB:`HBSP_STAT_SW_LSB] = openload_s & ~switch_on_q;
		end else begin
			status_now[`HBSP_STAT_SW_MSB:`HBSP_STAT_SW_LSB] = switch_on_q;
		end
		status_now[`HBSP_STAT_SCD] = |short_off;
		status_now[`HBSP_STAT_INH] = standby;
		status_now[`HBSP_STAT_PSF] = supply_fail_q;
		if (shutdown_q) begin
			status_now = {`HBSP_WORD_W{1'b1}};
		end
	end

	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= {`HBSP_WORD_W{1'b0}};
		end else begin
			status_q <= status_now;
		end
	end

	// ------------------------------------------------------------
	// serial frame engine
	// ------------------------------------------------------------
	// the first rising clock of a frame comes before any falling one, so the
	// transmit side only shifts once a bit has been taken; this keeps status
	// bit 0 on the line for the first sample. the bit last received fills the
	// top of the transmit word, which lets several devices be daisy-chained.
	reg active_q;
	reg [4:0] bit_cnt_q;
	reg [`HBSP_WORD_W-1:0] rx_q;
	reg [`HBSP_WORD_W-1:0] tx_q;
	reg sout_q;
	reg oe_q;

	always @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			active_q <= 1'b0;
			bit_cnt_q <= 5'h00;
			rx_q <= {`HBSP_WORD_W{1'b0}};
			tx_q <= {`HBSP_WORD_W{1'b0}};
			sout_q <= 1'b0;
			oe_q <= 1'b0;
			ctrl_q <= `HBSP_CTRL_RESET;
			clear_q <= 1'b0;
		end else begin
			clear_q <= 1'b0;
			if (cs_fall) begin
				active_q <= 1'b1;
				bit_cnt_q <= 5'h00;
				tx_q <= status_now;
				sout_q <= status_now[`HBSP_STAT_TP];
				oe_q <= 1'b1;
			end else if (cs_rise) begin
				active_q <= 1'b0;
				oe_q <= 1'b0;
				if (active_q && bit_cnt_q == `HBSP_FRAME_BITS) begin
					ctrl_q <= rx_q;
					clear_q <= rx_q[`HBSP_CTRL_CLR];
				end
				// a short frame leaves control and status untouched
			end else if (active_q) begin
				if (sclk_fall) begin
					rx_q <= {din_s, rx_q[`HBSP_WORD_W-1:1]};
					if (bit_cnt_q != `HBSP_FRAME_BITS) begin
						bit_cnt_q <= bit_cnt_q + 5'h01;
					end
				end
				if (sclk_rise && bit_cnt_q != 5'h00) begin
					tx_q <= {rx_q[`HBSP_WORD_W-1], tx_q[`HBSP_WORD_W-1:1]};
					sout_q <= tx_q[1];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign serial_out_o = sout_q;
	assign serial_out_oe_o = oe_q;
	assign switch_on_o = switch_on_q;
	assign openload_detect_en_o = old_en;
	assign short_delay_long_o = ctrl_q[`HBSP_CTRL_SCT];
	assign standby_o = standby;
	assign control_word_o = ctrl_q;
	assign status_word_o = status_q;
endmodule // hbsp_top
`default_nettype wire

// ---- bench/hbsp_checker.sv ----
// hbsp_checker.sv: port-level assertions for the half-bridge serial port
// assumes: bound to hbsp_top; the bench runs it with small short-delay counts
`timescale 1ns/10ps
`default_nettype none
`include "hbsp_regs.vh"
module hbsp_checker #(
	parameter [`HBSP_TMR_W-1:0] SHORT_LONG_CYC = 20'h927c0,
	parameter [`HBSP_TMR_W-1:0] SHORT_SHORT_CYC = 20'h124f8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic select_n_i,
	input wire logic temp_shutdown_i,
	input wire logic [`HBSP_NUM_SW-1:0] overcurrent_i,
	input wire logic serial_out_oe_o,
	input wire logic [`HBSP_NUM_SW-1:0] switch_on_o,
	input wire logic openload_detect_en_o,
	input wire logic short_delay_long_o,
	input wire logic standby_o,
	input wire logic [`HBSP_WORD_W-1:0] control_word_o,
	input wire logic [`HBSP_WORD_W-1:0] status_word_o
);
	// margin covers synchroniser and timer latency
	localparam int SB = SHORT_LONG_CYC + 30;
	int oc_n;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) oc_n <= 0;
		else oc_n <= (overcurrent_i[0] && switch_on_o[0]) ? oc_n + 1 : 0;
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_oe_idle; select_n_i [*6] |-> !serial_out_oe_o; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("driven while deselected");
	property p_oe_on; $fell(select_n_i) ##1 !select_n_i [*6] |-> serial_out_oe_o; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not enabled");
	property p_ctrl_frame; !select_n_i [*6] |-> $stable(control_word_o); endproperty
	a_ctrl_frame: assert property (p_ctrl_frame) else $error("word changed in frame");
	property p_sw_stby; standby_o |=> switch_on_o == '0; endproperty
	a_sw_stby: assert property (p_sw_stby) else $error("stage on in standby");
	property p_sw_ctrl; (switch_on_o & ~$past(control_word_o[12:1])) == '0; endproperty
	a_sw_ctrl: assert property (p_sw_ctrl) else $error("stage on without bit");
	property p_old; $stable(control_word_o) |-> openload_detect_en_o == !control_word_o[13];
	endproperty
	a_old: assert property (p_old) else $error("detect enable wrong");
	property p_sct; $stable(control_word_o) |-> short_delay_long_o == control_word_o[14];
	endproperty
	a_sct: assert property (p_sct) else $error("delay select wrong");
	property p_si; $stable(control_word_o) && !control_word_o[15] |-> standby_o; endproperty
	a_si: assert property (p_si) else $error("inhibit bit ignored");
	property p_inh_stat; reset_n_i [*6] ##0 standby_o [*3] |-> status_word_o[14]; endproperty
	a_inh_stat: assert property (p_inh_stat) else $error("standby flag low");
	property p_tshut; temp_shutdown_i [*8] |-> status_word_o == 16'hffff; endproperty
	a_tshut: assert property (p_tshut) else $error("shutdown not all ones");
	property p_short; oc_n <= SB; endproperty
	a_short: assert property (p_short) else $error("short not switched off");
	c_frame: cover property ($fell(select_n_i));
	c_tshut: cover property (status_word_o == 16'hffff);
	c_short: cover property (oc_n == 20);
endmodule // hbsp_checker
bind hbsp_top hbsp_checker #(.SHORT_LONG_CYC(SHORT_LONG_CYC),
	.SHORT_SHORT_CYC(SHORT_SHORT_CYC)) hbsp_checker_inst (.*);
`default_nettype wire

// ---- bench/hbsp_master.sv ----
// hbsp_master.sv: behavioural serial master facing the port
// assumes: clk_i is the bench clock; a link half period is four of its cycles
`timescale 1ns/10ps
`default_nettype none
module hbsp_master (
	input wire logic clk_i,
	input wire logic serial_out_i,
	input wire logic serial_out_oe_i,
	output logic select_n_o,
	output logic serial_clk_o,
	output logic serial_in_o
);
	logic last_q = 1'b0;
	initial begin
		select_n_o = 1'b1;
		serial_clk_o = 1'b0;
		serial_in_o = 1'b0;
	end
	// ------------------------------------------------------------
	// transfer
	// ------------------------------------------------------------
	// a released line shows the inverse of its last level
	task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] r);
		r = '0;
		@(posedge clk_i) select_n_o <= 1'b0;
		repeat (8) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			serial_clk_o <= 1'b1;
			serial_in_o <= w[i];
			repeat (4) @(posedge clk_i);
			serial_clk_o <= 1'b0;
			repeat (2) @(posedge clk_i);
			last_q = serial_out_oe_i ? serial_out_i : ~last_q;
			if (i < 16) r[i] = last_q;
			repeat (2) @(posedge clk_i);
		end
		select_n_o <= 1'b1;
		serial_in_o <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask
endmodule // hbsp_master
`default_nettype wire

// ---- bench/hbsp_top_test.sv ----
// hbsp_top_test.sv: self-checking bench for the half-bridge serial port
// assumes: design, partner model and checker compiled before it
`timescale 1ns/10ps
`default_nettype none
module hbsp_top_test;
	logic clk, rst_n, stby_n, tp, tsd, uv, sdo, sdo_oe, sel_n, sclk, sdi, opl, sdl, stby;
	logic [11:0] oc, ol, sw;
	logic [15:0] ctrl, stat, prev, rd;
	int errors, checks;
	hbsp_top #(.SHORT_LONG_CYC(20'h28), .SHORT_SHORT_CYC(20'ha)) hbsp_top_inst (
		.clk_i(clk), .reset_n_i(rst_n), .select_n_i(sel_n), .serial_clk_i(sclk),
		.serial_in_i(sdi), .standby_pin_n_i(stby_n), .temp_prewarn_i(tp),
		.temp_shutdown_i(tsd), .supply_undervolt_i(uv), .overcurrent_i(oc),
		.openload_i(ol), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
		.switch_on_o(sw), .openload_detect_en_o(opl), .short_delay_long_o(sdl),
		.standby_o(stby), .control_word_o(ctrl), .status_word_o(stat));
	hbsp_master hbsp_master_inst (.clk_i(clk), .serial_out_i(sdo),
		.serial_out_oe_i(sdo_oe), .select_n_o(sel_n), .serial_clk_o(sclk), .serial_in_o(sdi));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] exp_stat(logic [15:0] c, logic p, logic t, logic [11:0] o);
		logic s;
		logic [11:0] on;
		s = !c[15] || !p;
		on = s ? 12'h000 : c[12:1];
		return {1'b0, s, 1'b0, c[13] ? on : (o & ~on), t};
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic outs(input logic [15:0] c);
		logic s;
		s = !c[15] || !stby_n;
		cmp(ctrl, c);
		cmp({1'b0, sw, opl, sdl, stby}, {1'b0, s ? 12'h0 : c[12:1], !c[13], c[14], s});
	endtask
	task automatic set_in(input logic p, input logic t, input logic [11:0] o);
		@(posedge clk);
		stby_n <= p;
		tp <= t;
		ol <= o;
		repeat (10) @(posedge clk);
	endtask
	task automatic frame(input logic [31:0] w, input int n);
		hbsp_master_inst.xfer(w, n, rd);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out;
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [15:0] w;
		{rst_n, tp, tsd, uv, oc, ol, errors, checks} = '0;
		stby_n = 1'b1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		cmp(ctrl, 16'he000);
		cmp({4'h0, sw}, 16'h0);
		$display("test reset done");
		void'($urandom(61));
		prev = 16'he000;
		for (int k = 0; k < 12; k++) begin
			r = $urandom;
			w = r[31:16];
			set_in(|r[1:0], r[2], r[14:3]);
			frame({16'h0, w}, 16);
			cmp(rd, exp_stat(prev, stby_n, tp, ol));
			outs(w);
			prev = w;
		end
		$display("test random done");
		set_in(1'b1, 1'b1, 12'h0);
		frame(32'hffff, 5);
		cmp({15'h0, rd[0]}, 16'h1);
		cmp(ctrl, prev);
		w = 16'he00b;
		frame({12'h0, w, 4'h5}, 20);
		outs(w);
		$display("test frame length done");
		@(posedge clk) oc <= 12'h001;
		repeat (80) @(posedge clk);
		cmp({4'h0, sw}, 16'h0004);
		oc <= 12'h000;
		frame({16'h0, w}, 16);
		cmp(rd, exp_stat(16'he009, 1'b1, 1'b1, 12'h0) | 16'h2000);
		outs(w);
		frame({16'h0, w}, 16);
		cmp(rd, exp_stat(w, 1'b1, 1'b1, 12'h0));
		$display("test short done");
		@(posedge clk) uv <= 1'b1;
		repeat (10) @(posedge clk);
		frame(32'he00a, 16);
		cmp(rd, 16'h8001);
		@(posedge clk) tsd <= 1'b1;
		repeat (10) @(posedge clk);
		frame({16'h0, w}, 16);
		cmp(rd, 16'hffff);
		cmp({4'h0, sw}, 16'h0);
		@(posedge clk) tsd <= 1'b0;
		uv <= 1'b0;
		repeat (10) @(posedge clk);
		frame({16'h0, w}, 16);
		cmp(rd, 16'hffff);
		frame({16'h0, w}, 16);
		cmp(rd, exp_stat(w, 1'b1, 1'b1, 12'h0));
		$display("test faults done");
		close_out;
	end
endmodule // hbsp_top_test
`default_nettype wire
